// ===== hdl/phy_mgmt_pkg.sv
// Shared constants and types for the transceiver management register bank
`default_nettype none
package phy_mgmt_pkg;

	// Transceiver port addresses answered on the management link
	localparam logic [4:0] PORT_ADDR_FIRST = 5'h02;
	localparam logic [4:0] PORT_ADDR_SECOND = 5'h03;

	// Register indexes
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_STAT = 5'h01;
	localparam logic [4:0] REG_ID_UPPER = 5'h02;
	localparam logic [4:0] REG_ID_LOWER = 5'h03;
	localparam logic [4:0] REG_ADV = 5'h04;
	localparam logic [4:0] REG_PARTNER = 5'h05;
	localparam logic [4:0] REG_RSVD_HIGH = 5'h1D;
	localparam logic [4:0] REG_SPECIAL = 5'h1F;

	// Control register bit positions
	localparam int CTRL_SPEED_BIT = 13;
	localparam int CTRL_AN_EN_BIT = 12;
	localparam int CTRL_RESTART_BIT = 9;
	localparam int CTRL_DUPLEX_BIT = 8;
	localparam int CTRL_XALG_BIT = 5;
	localparam int CTRL_STRAIGHT_BIT = 4;
	localparam int CTRL_XOFF_BIT = 3;
	localparam int CTRL_FAULT_OFF_BIT = 2;
	localparam int CTRL_TX_OFF_BIT = 1;
	localparam int CTRL_IND_OFF_BIT = 0;
	localparam logic [15:0] CTRL_WMASK = 16'h313F;
	localparam logic [15:0] CTRL_RESET = 16'h3020;

	// Status register layout
	localparam int STAT_DONE_BIT = 5;
	localparam int STAT_FAULT_BIT = 4;
	localparam int STAT_LINK_BIT = 2;
	localparam logic [15:0] STAT_FIXED = 16'h7808;
	localparam logic [15:0] STAT_FIXED_MASK = 16'hFFCB;

	// Advertisement register layout
	localparam logic [15:0] ADV_WMASK = 16'h07E0;
	localparam logic [15:0] ADV_RESET = 16'h05E0;
	localparam logic [15:0] ADV_SELECTOR = 16'h0001;
	localparam logic [15:0] PARTNER_WORD = 16'h0001;
	localparam logic [15:0] ZERO_WORD = 16'h0000;

	// Frame layout
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [5:0] PRE_LEN = 6'h20;
	localparam logic [5:0] HDR_LAST = 6'h0B;
	localparam logic [5:0] TA_LAST = 6'h01;
	localparam logic [5:0] DATA_LAST = 6'h0F;
	localparam logic [5:0] CNT_ONE = 6'h01;

	typedef enum logic [2:0] {
		S_PRE = 3'b000,
		S_ST = 3'b001,
		S_HDR = 3'b010,
		S_TA = 3'b011,
		S_DATA = 3'b100
	} frame_state_e;

	typedef struct packed {
		logic autoneg_restart;
		logic autoneg_enable;
		logic speed_100;
		logic duplex_full;
		logic crossover_algorithm_select;
		logic crossover_force_straight;
		logic crossover_auto_off;
		logic far_fault_detect_off;
		logic transmit_off;
		logic indicator_off;
	} port_ctrl_s;

	typedef struct packed {
		logic link_up;
		logic autoneg_done;
		logic far_end_fault;
	} port_stat_s;

endpackage : phy_mgmt_pkg
`default_nettype wire

// ===== hdl/mgmt_link_sampler.sv
// Synchroniser and rising-edge finder for the management clock and data pins
`timescale 1ns/1ps
`default_nettype none
module mgmt_link_sampler (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// Link pins
	input wire logic mdc_in,
	input wire logic mdio_in,
	// Sampled link
	output var logic mdc_rise_out,
	output var logic mdio_bit_out
);

	logic mdc_meta_q;
	logic mdc_sync_q;
	logic mdc_prev_q;
	logic mdio_meta_q;
	logic mdio_sync_q;

	// Data and clock take equal delay so the data bit lines up with the edge
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			mdc_meta_q <= 1'b0;
			mdc_sync_q <= 1'b0;
			mdc_prev_q <= 1'b0;
			mdio_meta_q <= 1'b1;
			mdio_sync_q <= 1'b1;
			mdc_rise_out <= 1'b0;
			mdio_bit_out <= 1'b1;
		end else begin
			mdc_meta_q <= mdc_in;
			mdc_sync_q <= mdc_meta_q;
			mdc_prev_q <= mdc_sync_q;
			mdio_meta_q <= mdio_in;
			mdio_sync_q <= mdio_meta_q;
			mdc_rise_out <= mdc_sync_q & ~mdc_prev_q;
			mdio_bit_out <= mdio_sync_q;
		end
	end

endmodule : mgmt_link_sampler
`default_nettype wire

// ===== hdl/phy_mgmt_register_bank.sv
// Management register bank for two copper transceiver ports
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_register_bank #(
	// Identifier halves; values are arbitrary
	parameter logic [15:0] IDENT_UPPER = 16'hA5A5,
	parameter logic [15:0] IDENT_LOWER = 16'h5A01
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// Management link pins
	input wire logic mdc_in,
	input wire logic mdio_in,
	output var logic mdio_out,
	output var logic mdio_oe_n_out,
	// Per-port state from the transceiver logic
	input wire phy_mgmt_pkg::port_stat_s [1:0] port_stat_in,
	// Per-port settings to the transceiver logic
	output var phy_mgmt_pkg::port_ctrl_s [1:0] port_ctrl_out
);

	function automatic logic reg_known(input logic [4:0] idx);
		return (idx <= phy_mgmt_pkg::REG_PARTNER) ||
			(idx == phy_mgmt_pkg::REG_RSVD_HIGH) ||
			(idx == phy_mgmt_pkg::REG_SPECIAL);
	endfunction : reg_known

	function automatic logic addr_ours(input logic [4:0] addr);
		return (addr == phy_mgmt_pkg::PORT_ADDR_FIRST) ||
			(addr == phy_mgmt_pkg::PORT_ADDR_SECOND);
	endfunction : addr_ours

	function automatic logic frame_hit(input logic [11:0] hdr);
		logic op_ok;
		op_ok = (hdr[11:10] == phy_mgmt_pkg::OP_READ) ||
			(hdr[11:10] == phy_mgmt_pkg::OP_WRITE);
		return op_ok && addr_ours(hdr[9:5]) && reg_known(hdr[4:0]);
	endfunction : frame_hit

	function automatic logic [15:0] stat_word(
		input phy_mgmt_pkg::port_stat_s st,
		input logic fault_off
	);
		logic [15:0] w;
		w = phy_mgmt_pkg::STAT_FIXED;
		w[phy_mgmt_pkg::STAT_DONE_BIT] = st.autoneg_done;
		w[phy_mgmt_pkg::STAT_FAULT_BIT] = st.far_end_fault & ~fault_off;
		w[phy_mgmt_pkg::STAT_LINK_BIT] = st.link_up;
		return w;
	endfunction : stat_word

	function automatic phy_mgmt_pkg::port_ctrl_s ctrl_map(
		input logic [15:0] c,
		input logic restart
	);
		phy_mgmt_pkg::port_ctrl_s s;
		s.autoneg_restart = restart;
		s.autoneg_enable = c[phy_mgmt_pkg::CTRL_AN_EN_BIT];
		s.speed_100 = c[phy_mgmt_pkg::CTRL_SPEED_BIT];
		s.duplex_full = c[phy_mgmt_pkg::CTRL_DUPLEX_BIT] &
			~c[phy_mgmt_pkg::CTRL_AN_EN_BIT];
		s.crossover_algorithm_select = c[phy_mgmt_pkg::CTRL_XALG_BIT];
		s.crossover_force_straight = c[phy_mgmt_pkg::CTRL_STRAIGHT_BIT] &
			c[phy_mgmt_pkg::CTRL_XOFF_BIT];
		s.crossover_auto_off = c[phy_mgmt_pkg::CTRL_XOFF_BIT];
		s.far_fault_detect_off = c[phy_mgmt_pkg::CTRL_FAULT_OFF_BIT];
		s.transmit_off = c[phy_mgmt_pkg::CTRL_TX_OFF_BIT];
		s.indicator_off = c[phy_mgmt_pkg::CTRL_IND_OFF_BIT];
		return s;
	endfunction : ctrl_map

	logic mdc_rise;
	logic mdio_bit;
	phy_mgmt_pkg::frame_state_e state_q;
	phy_mgmt_pkg::frame_state_e state_d;
	logic [5:0] cnt_q;
	logic [5:0] cnt_d;
	logic [11:0] hdr_q;
	logic [15:0] shift_q;
	logic [15:0] ctrl_q [2];
	logic [15:0] adv_q [2];
	phy_mgmt_pkg::port_stat_s [1:0] stat_q;
	logic [15:0] rd_word;

	mgmt_link_sampler u_sampler (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.mdc_in(mdc_in),
		.mdio_in(mdio_in),
		.mdc_rise_out(mdc_rise),
		.mdio_bit_out(mdio_bit)
	);

	// Header fields, stable once the header has been shifted in
	wire [11:0] hdr_next = {hdr_q[10:0], mdio_bit};
	wire [1:0] hdr_op = hdr_q[11:10];
	wire [4:0] hdr_reg = hdr_q[4:0];
	wire hdr_port = (hdr_q[9:5] == phy_mgmt_pkg::PORT_ADDR_SECOND);
	wire rd_frame = (hdr_op == phy_mgmt_pkg::OP_READ);
	wire hdr_done = (state_q == phy_mgmt_pkg::S_HDR) &&
		(cnt_q == phy_mgmt_pkg::HDR_LAST);
	wire ta_last = (state_q == phy_mgmt_pkg::S_TA) &&
		(cnt_q == phy_mgmt_pkg::TA_LAST);
	wire data_last = (state_q == phy_mgmt_pkg::S_DATA) &&
		(cnt_q == phy_mgmt_pkg::DATA_LAST);
	wire [15:0] wr_data = {shift_q[14:0], mdio_bit};
	wire wr_commit = mdc_rise && data_last &&
		(hdr_op == phy_mgmt_pkg::OP_WRITE);
	wire ctrl_wr = wr_commit && (hdr_reg == phy_mgmt_pkg::REG_CTRL);
	wire adv_wr = wr_commit && (hdr_reg == phy_mgmt_pkg::REG_ADV);
	wire restart_req = ctrl_wr && wr_data[phy_mgmt_pkg::CTRL_RESTART_BIT];
	wire [1:0] restart_hit = {restart_req && hdr_port,
		restart_req && !hdr_port};

	// Read selection; unlisted bits of every word stay zero
	always_comb begin
		if (hdr_reg == phy_mgmt_pkg::REG_CTRL) begin
			rd_word = ctrl_q[hdr_port];
		end else if (hdr_reg == phy_mgmt_pkg::REG_STAT) begin
			rd_word = stat_word(stat_q[hdr_port],
				ctrl_q[hdr_port][phy_mgmt_pkg::CTRL_FAULT_OFF_BIT]);
		end else if (hdr_reg == phy_mgmt_pkg::REG_ID_UPPER) begin
			rd_word = IDENT_UPPER;
		end else if (hdr_reg == phy_mgmt_pkg::REG_ID_LOWER) begin
			rd_word = IDENT_LOWER;
		end else if (hdr_reg == phy_mgmt_pkg::REG_ADV) begin
			rd_word = adv_q[hdr_port] | phy_mgmt_pkg::ADV_SELECTOR;
		end else if (hdr_reg == phy_mgmt_pkg::REG_PARTNER) begin
			rd_word = phy_mgmt_pkg::PARTNER_WORD;
		end else begin
			rd_word = phy_mgmt_pkg::ZERO_WORD;
		end
	end

	// Frame sequencer: preamble, start, header, turnaround, data
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		if (mdc_rise) begin
			case (state_q)
				phy_mgmt_pkg::S_PRE: begin
					if (mdio_bit) begin
						if (cnt_q != phy_mgmt_pkg::PRE_LEN) begin
							cnt_d = cnt_q + phy_mgmt_pkg::CNT_ONE;
						end
					end else if (cnt_q == phy_mgmt_pkg::PRE_LEN) begin
						state_d = phy_mgmt_pkg::S_ST;
						cnt_d = '0;
					end else begin
						cnt_d = '0;
					end
				end
				phy_mgmt_pkg::S_ST: begin
					state_d = mdio_bit ? phy_mgmt_pkg::S_HDR : phy_mgmt_pkg::S_PRE;
					cnt_d = '0;
				end
				phy_mgmt_pkg::S_HDR: begin
					if (cnt_q == phy_mgmt_pkg::HDR_LAST) begin
						// Foreign addresses and unknown indexes are not answered
						state_d = frame_hit(hdr_next) ? phy_mgmt_pkg::S_TA :
							phy_mgmt_pkg::S_PRE;
						cnt_d = '0;
					end else begin
						cnt_d = cnt_q + phy_mgmt_pkg::CNT_ONE;
					end
				end
				phy_mgmt_pkg::S_TA: begin
					if (cnt_q == phy_mgmt_pkg::TA_LAST) begin
						state_d = phy_mgmt_pkg::S_DATA;
						cnt_d = '0;
					end else begin
						cnt_d = cnt_q + phy_mgmt_pkg::CNT_ONE;
					end
				end
				phy_mgmt_pkg::S_DATA: begin
					if (cnt_q == phy_mgmt_pkg::DATA_LAST) begin
						state_d = phy_mgmt_pkg::S_PRE;
						cnt_d = '0;
					end else begin
						cnt_d = cnt_q + phy_mgmt_pkg::CNT_ONE;
					end
				end
				default: begin
					state_d = phy_mgmt_pkg::S_PRE;
					cnt_d = '0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			state_q <= phy_mgmt_pkg::S_PRE;
			cnt_q <= '0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// Header and data shifters; read data is loaded at the turnaround's end
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			hdr_q <= '0;
			shift_q <= '0;
		end else if (mdc_rise) begin
			if (state_q == phy_mgmt_pkg::S_HDR) begin
				hdr_q <= hdr_next;
			end
			shift_q <= ta_last ? rd_word : wr_data;
		end
	end

	// Pin drive: zero in the second turnaround bit, then data MSB first
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			mdio_out <= 1'b1;
			mdio_oe_n_out <= 1'b1;
		end else if (mdc_rise && rd_frame) begin
			if ((state_q == phy_mgmt_pkg::S_TA) && !ta_last) begin
				mdio_oe_n_out <= 1'b0;
				mdio_out <= 1'b0;
			end else if (ta_last) begin
				mdio_out <= rd_word[15];
			end else if (data_last) begin
				mdio_oe_n_out <= 1'b1;
				mdio_out <= 1'b1;
			end else if (state_q == phy_mgmt_pkg::S_DATA) begin
				mdio_out <= shift_q[14];
			end
		end
	end

	// Writable fields only; fixed bits keep their values
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			ctrl_q[0] <= phy_mgmt_pkg::CTRL_RESET;
			ctrl_q[1] <= phy_mgmt_pkg::CTRL_RESET;
			adv_q[0] <= phy_mgmt_pkg::ADV_RESET;
			adv_q[1] <= phy_mgmt_pkg::ADV_RESET;
		end else if (ctrl_wr) begin
			ctrl_q[hdr_port] <= wr_data & phy_mgmt_pkg::CTRL_WMASK;
		end else if (adv_wr) begin
			adv_q[hdr_port] <= wr_data & phy_mgmt_pkg::ADV_WMASK;
		end
	end

	// Live port state, zero after reset
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			stat_q <= '0;
		end else begin
			stat_q <= port_stat_in;
		end
	end

	// Settings to the port logic
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			port_ctrl_out[0] <= ctrl_map(phy_mgmt_pkg::CTRL_RESET, 1'b0);
			port_ctrl_out[1] <= ctrl_map(phy_mgmt_pkg::CTRL_RESET, 1'b0);
		end else begin
			port_ctrl_out[0] <= ctrl_map(ctrl_q[0], restart_hit[0]);
			port_ctrl_out[1] <= ctrl_map(ctrl_q[1], restart_hit[1]);
		end
	end

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (rst_in);

	restart_pulse_a:
	assert property (restart_hit[1] |=> port_ctrl_out[1].autoneg_restart
		##1 !port_ctrl_out[1].autoneg_restart || restart_hit[1])
		else $error("restart pulse missing on second port");

	forced_duplex_a:
	assert property (port_ctrl_out[0].duplex_full |->
		$past(ctrl_q[0][phy_mgmt_pkg::CTRL_DUPLEX_BIT]) &&
		!port_ctrl_out[0].autoneg_enable)
		else $error("full duplex forced while negotiation enabled");

	reset_values_a:
	assert property ($past(rst_in) |-> port_ctrl_out[0].speed_100 &&
		port_ctrl_out[0].crossover_algorithm_select &&
		!port_ctrl_out[0].duplex_full)
		else $error("control reset values wrong");

	straight_gate_a:
	assert property (port_ctrl_out[1].crossover_force_straight |->
		port_ctrl_out[1].crossover_auto_off)
		else $error("straight pairs forced with auto crossover active");

	ctrl_fixed_a:
	assert property ((ctrl_q[0] & ~phy_mgmt_pkg::CTRL_WMASK) == '0 &&
		(ctrl_q[1] & ~phy_mgmt_pkg::CTRL_WMASK) == '0)
		else $error("fixed control bits became set");

	status_fixed_a:
	assert property ((hdr_reg == phy_mgmt_pkg::REG_STAT) |->
		(rd_word & phy_mgmt_pkg::STAT_FIXED_MASK) ==
		phy_mgmt_pkg::STAT_FIXED)
		else $error("fixed status bits wrong");

	link_track_a:
	assert property (port_stat_in[1].link_up ##1 port_stat_in[1].link_up
		|-> stat_q[1].link_up)
		else $error("link state not reflected");

	ident_read_a:
	assert property ((hdr_reg == phy_mgmt_pkg::REG_ID_LOWER) |->
		rd_word == IDENT_LOWER)
		else $error("identifier word wrong");

	adv_top_a:
	assert property ((hdr_reg == phy_mgmt_pkg::REG_ADV) |->
		rd_word[15:13] == 3'h0 && rd_word[4:0] == 5'h01)
		else $error("advertisement fixed bits wrong");

	turnaround_drive_a:
	assert property (mdc_rise && state_q == phy_mgmt_pkg::S_TA && !ta_last &&
		rd_frame |=> !mdio_oe_n_out && !mdio_out)
		else $error("turnaround zero not driven");

	foreign_quiet_a:
	assert property (mdc_rise && hdr_done && !frame_hit(hdr_next) |=>
		state_q == phy_mgmt_pkg::S_PRE && mdio_oe_n_out)
		else $error("answered a foreign frame");

	release_pin_a:
	assert property (mdc_rise && data_last |=> mdio_oe_n_out)
		else $error("pin not released after data");

	write_quiet_a:
	assert property (state_q == phy_mgmt_pkg::S_DATA && !rd_frame |->
		mdio_oe_n_out)
		else $error("pin driven during a write");

	read_frame_c: cover property (mdc_rise && data_last && rd_frame);
	write_frame_c: cover property (ctrl_wr);
	restart_c: cover property (port_ctrl_out[0].autoneg_restart);
	foreign_c: cover property (mdc_rise && hdr_done && !frame_hit(hdr_next));

endmodule : phy_mgmt_register_bank
`default_nettype wire

// ===== tb/mgmt_station_model.sv
// Management station model that frames reads and writes on the link pins
`timescale 1ns/1ps
`default_nettype none
module mgmt_station_model (
	// Resolved data line
	input wire logic mdio_wire_in,
	// Station pins
	output var logic mdc_out,
	output var logic mdio_drive_out,
	output var logic mdio_oe_out
);
	// Clock stands low and the line is released between frames
	initial begin
		mdc_out = 1'b0;
		mdio_drive_out = 1'b1;
		mdio_oe_out = 1'b0;
	end

	// Bit 16 of rd_data is the second turnaround bit
	task automatic frame(input logic [1:0] op, input logic [4:0] port,
		input logic [4:0] idx, input logic [15:0] wr_data,
		output logic [16:0] rd_data);
		logic [63:0] bits;
		bits = {32'hFFFFFFFF, 2'b01, op, port, idx, 2'b10, wr_data};
		// Pin changes land on system clock edges, so they go non-blocking
		for (int i = 0; i < 64; i++) begin
			#80;
			mdio_oe_out <= (i < 46) || (op != phy_mgmt_pkg::OP_READ);
			mdio_drive_out <= bits[63 - i];
			#80;
			mdc_out <= 1'b1;
			if (i >= 47)
				rd_data[63 - i] = mdio_wire_in;
			#160;
			mdc_out <= 1'b0;
		end
		#80;
		mdio_oe_out <= 1'b0;
		#400;
	endtask : frame
endmodule : mgmt_station_model
`default_nettype wire

// ===== tb/tb_phy_mgmt_register_bank.sv
// Self-checking bench for the management register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
	tests_run++; \
	if ((got) !== (exp)) begin \
		err_total++; \
		$display("[ERR] %0t got %h expected %h", $time, (got), (exp)); \
	end \
end
module tb_phy_mgmt_register_bank;
	// Identifier halves; values are arbitrary
	localparam logic [15:0] ID_HI = 16'hC3C3;
	localparam logic [15:0] ID_LO = 16'h3C07;
	logic sys_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic mdc;
	logic st_drive;
	logic st_oe;
	logic mdio_out;
	logic mdio_oe_n_out;
	wire logic mdio_wire;
	phy_mgmt_pkg::port_stat_s [1:0] port_stat_in = '0;
	phy_mgmt_pkg::port_ctrl_s [1:0] port_ctrl_out;
	int err_total = 0;
	int tests_run = 0;
	int pulse0 = 0;
	int pulse1 = 0;
	int drove_cnt = 0;
	logic [16:0] rd;

	always #20 sys_clk_in = ~sys_clk_in;

	// Pull-up when neither side drives
	assign mdio_wire = !mdio_oe_n_out ? mdio_out : (st_oe ? st_drive : 1'b1);

	always @(posedge sys_clk_in) begin
		if (port_ctrl_out[0].autoneg_restart === 1'b1)
			pulse0++;
		if (port_ctrl_out[1].autoneg_restart === 1'b1)
			pulse1++;
		if (mdio_oe_n_out === 1'b0)
			drove_cnt++;
	end

	mgmt_station_model i_station (
		.mdio_wire_in(mdio_wire),
		.mdc_out(mdc),
		.mdio_drive_out(st_drive),
		.mdio_oe_out(st_oe)
	);

	phy_mgmt_register_bank #(
		.IDENT_UPPER(ID_HI),
		.IDENT_LOWER(ID_LO)
	) i_dut (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.mdc_in(mdc),
		.mdio_in(mdio_wire),
		.mdio_out(mdio_out),
		.mdio_oe_n_out(mdio_oe_n_out),
		.port_stat_in(port_stat_in),
		.port_ctrl_out(port_ctrl_out)
	);

	// Settings expected at the transceiver side for a control word
	function automatic logic [9:0] ctrl_map(input logic [15:0] w);
		return {1'b0, w[12], w[13], w[8] & ~w[12], w[5], w[4] & w[3], w[3],
			w[2], w[1], w[0]};
	endfunction : ctrl_map

	task automatic xfer(input logic [1:0] op, input logic [4:0] port,
		input logic [4:0] idx, input logic [15:0] wd);
		i_station.frame(op, port, idx, wd, rd);
		repeat (8) @(posedge sys_clk_in);
	endtask : xfer

	task automatic wr(input logic [4:0] port, input logic [4:0] idx,
		input logic [15:0] wd);
		xfer(phy_mgmt_pkg::OP_WRITE, port, idx, wd);
	endtask : wr

	task automatic rd_chk(input logic [4:0] port, input logic [4:0] idx,
		input logic [15:0] exp);
		logic [16:0] want;
		want = {1'b0, exp};
		xfer(phy_mgmt_pkg::OP_READ, port, idx, 16'h0000);
		`CHK(rd, want)
	endtask : rd_chk

	// Frame that must leave the line undriven
	task automatic nak(input logic [1:0] op, input logic [4:0] port,
		input logic [4:0] idx);
		int base;
		base = drove_cnt;
		xfer(op, port, idx, 16'hFFFF);
		`CHK(drove_cnt - base, 0)
	endtask : nak

	task automatic t_reset();
		for (int p = 0; p < 2; p++) begin
			`CHK(port_ctrl_out[p], ctrl_map(16'h3020))
			rd_chk(5'h02 + 5'(p), 5'h00, 16'h3020);
		end
		rd_chk(5'h02, 5'h01, 16'h7808);
		rd_chk(5'h02, 5'h02, ID_HI);
		rd_chk(5'h03, 5'h03, ID_LO);
		rd_chk(5'h02, 5'h04, 16'h05E1);
		rd_chk(5'h03, 5'h05, 16'h0001);
		rd_chk(5'h02, 5'h1D, 16'h0000);
		rd_chk(5'h03, 5'h1F, 16'h0000);
	endtask : t_reset

	task automatic t_ctrl();
		wr(5'h02, 5'h00, 16'hFFFF);
		`CHK(pulse0, 1)
		`CHK(pulse1, 0)
		`CHK(port_ctrl_out[0], ctrl_map(16'hFFFF))
		`CHK(port_ctrl_out[1], ctrl_map(16'h3020))
		rd_chk(5'h02, 5'h00, 16'h313F);
		wr(5'h02, 5'h00, 16'h0118);
		`CHK(pulse0, 1)
		`CHK(port_ctrl_out[0], ctrl_map(16'h0118))
		wr(5'h02, 5'h00, 16'h1110);
		`CHK(port_ctrl_out[0], ctrl_map(16'h1110))
		rd_chk(5'h02, 5'h00, 16'h1110);
	endtask : t_ctrl

	task automatic t_status();
		logic [15:0] exp [3];
		exp = '{16'h780C, 16'h7828, 16'h7818};
		for (int k = 0; k < 3; k++) begin
			@(posedge sys_clk_in);
			port_stat_in[1] <= 3'b100 >> k;
			rd_chk(5'h03, 5'h01, exp[k]);
		end
		rd_chk(5'h02, 5'h01, 16'h7808);
		wr(5'h03, 5'h00, 16'h3224);
		`CHK(pulse1, 1)
		`CHK(port_ctrl_out[1], ctrl_map(16'h3024))
		rd_chk(5'h03, 5'h01, 16'h7808);
	endtask : t_status

	task automatic t_refused();
		nak(phy_mgmt_pkg::OP_READ, 5'h01, 5'h00);
		nak(phy_mgmt_pkg::OP_READ, 5'h04, 5'h01);
		nak(phy_mgmt_pkg::OP_READ, 5'h05, 5'h02);
		nak(phy_mgmt_pkg::OP_READ, 5'h02, 5'h06);
		nak(phy_mgmt_pkg::OP_READ, 5'h03, 5'h1E);
		nak(2'b11, 5'h02, 5'h00);
		nak(2'b00, 5'h02, 5'h00);
		nak(phy_mgmt_pkg::OP_WRITE, 5'h04, 5'h00);
		rd_chk(5'h02, 5'h00, 16'h1110);
		wr(5'h02, 5'h01, 16'h0000);
		wr(5'h02, 5'h02, 16'h0000);
		wr(5'h02, 5'h04, 16'hFFFF);
		rd_chk(5'h02, 5'h01, 16'h7808);
		rd_chk(5'h02, 5'h02, ID_HI);
		rd_chk(5'h02, 5'h04, 16'h07E1);
	endtask : t_refused

	task automatic close_out();
		if (err_total == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out

	initial begin
		repeat (12) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		repeat (8) @(posedge sys_clk_in);
		t_reset();
		t_ctrl();
		t_status();
		t_refused();
		close_out();
	end

	// Thirty-five frames of about 21 us each fit well inside this span
	initial begin
		#2000000;
		err_total++;
		close_out();
	end
endmodule : tb_phy_mgmt_register_bank
`default_nettype wire
